// ---- rtl/dcspi_slave.sv ----
`timescale 1ns/1ps
// Functional notes
// - Each packet is control byte, address byte, then data byte.
// - Control bit 6 selects read when set; bit 7 is broadcast.
// - Control bits 4..0 hold chain position bits 0..4 reversed; bit 5 zero.
// - Second byte is the 8-bit register address, MSB first.
// - Third byte is write data in, or read data out.
// - Data out is driven only during a read's final byte.
// - Each byte is eight consecutive rising clock edges with select low.
// - Byte counter advances on the next byte's first rising clock edge after eight bits.
// - Early select rise or extra clocks may lose packet sync.
// - Clock edge with select high resets the packet machine.
// - An interrupted packet is dropped; its write target stays unchanged.
// - Broadcast is ignored on reads; only position zero answers.
// - Reads of absent registers return all zeros.
// - Broadcast write updates all devices, else only position zero.
// - Chain position is decremented as the control byte passes through.
// - Other bits pass unchanged; position zero means addressed.
// - Writes to absent registers change nothing.
// - Data out stays released for a whole write packet.
// - Broadcast writes ignore chain position and update the register.
module dcspi_slave
    import dcspi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sclk,
    input  wire logic       device_select_n,
    input  wire logic       serial_data_in,
    output logic            serial_data_out,
    output logic            serial_data_out_oe_n,
    output logic            serial_passthrough_out,
    output logic [7:0]      reg_rd_addr,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_hit,
    output logic            reg_wr_en,
    output logic [7:0]      reg_wr_addr,
    output logic [7:0]      reg_wr_data,
    input  wire logic       reg_wr_hit
);
    // Link side
    logic [3:0]        bit_cnt;
    logic [1:0]        byte_idx;
    logic [1:0]        cur_idx;
    logic              byte_full;
    logic              lost;
    logic [6:0]        shreg;
    logic [7:0]        rx_byte;
    logic              borrow;
    logic              cid_field;
    logic              ctrl_rnw;
    logic              ctrl_brd;
    logic              ctrl_cid0;
    logic [7:0]        addr_hold;
    logic [7:0]        wdata_hold;
    logic              rd_tgl;
    logic              wr_tgl;
    logic              abort_tgl;
    // Core side
    logic [SYNC_W-1:0] sy;
    logic [SYNC_W-1:0] sy_prev;
    logic              sel_rise;
    logic              sclk_fall;
    logic              resync;
    logic              rd_evt;
    logic              wr_evt;
    logic              ab_evt;
    dcspi_rd_t         rd_state;
    dcspi_wr_t         wr_state;
    logic [7:0]        rd_shift;

    assign rx_byte = {shreg, serial_data_in};

    always_comb begin
        cur_idx = byte_idx;
        if (bit_cnt == CNT_RST && byte_full) begin
            cur_idx = (byte_idx == IDX_DATA) ? IDX_CTRL : byte_idx + 2'h1;
        end
    end

    always_ff @(posedge sclk or negedge rst_n or posedge device_select_n) begin
        if (!rst_n) begin
            bit_cnt <= CNT_RST;
        end else if (device_select_n) begin
            bit_cnt <= CNT_RST;
        end else if (bit_cnt != OVER_BIT_CNT) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            byte_idx  <= IDX_CTRL;
            byte_full <= 1'b0;
            lost      <= 1'b0;
        end else if (device_select_n) begin
            byte_idx  <= IDX_CTRL;
            byte_full <= 1'b0;
            lost      <= 1'b0;
        end else begin
            byte_idx <= cur_idx;
            if (bit_cnt == LAST_BIT_CNT && !lost) begin
                byte_full <= 1'b1;
            end else if (bit_cnt == CNT_RST) begin
                byte_full <= 1'b0;
            end
            if (bit_cnt == OVER_BIT_CNT) begin
                lost <= 1'b1;
            end
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 7'h00;
        end else if (!device_select_n) begin
            shreg <= rx_byte[6:0];
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_rnw   <= 1'b0;
            ctrl_brd   <= 1'b0;
            ctrl_cid0  <= 1'b0;
            addr_hold  <= BYTE_RST;
            wdata_hold <= BYTE_RST;
            rd_tgl     <= 1'b0;
            wr_tgl     <= 1'b0;
        end else if (!device_select_n && !lost && bit_cnt == LAST_BIT_CNT) begin
            case (cur_idx)
                IDX_CTRL: begin
                    ctrl_rnw  <= rx_byte[RNW_POS];
                    ctrl_brd  <= rx_byte[BRD_POS];
                    ctrl_cid0 <= rx_byte[CID_MSB:0] == CID_ZERO;
                end
                IDX_ADDR: begin
                    addr_hold <= rx_byte;
                    if (ctrl_rnw && ctrl_cid0) begin
                        rd_tgl <= ~rd_tgl;
                    end
                end
                IDX_DATA: begin
                    if (!ctrl_rnw && (ctrl_brd || ctrl_cid0)) begin
                        wdata_hold <= rx_byte;
                        wr_tgl     <= ~wr_tgl;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            abort_tgl <= 1'b0;
        end else if (!device_select_n && bit_cnt == OVER_BIT_CNT
                     && byte_idx == IDX_DATA && byte_full) begin
            abort_tgl <= ~abort_tgl;
        end
    end

    assign cid_field = !lost && byte_idx == IDX_CTRL
                       && bit_cnt >= CID_FIRST_CNT && bit_cnt <= LAST_BIT_CNT;

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            borrow <= 1'b1;
        end else if (cid_field && !device_select_n) begin
            borrow <= borrow & ~serial_data_in;
        end else begin
            borrow <= 1'b1;
        end
    end

    assign serial_passthrough_out = serial_data_in ^ (cid_field & borrow);

    // Crossing of select, clock and toggles into clk domain
    dcspi_xing_if xing ();
    assign xing.async_in = {abort_tgl, wr_tgl, rd_tgl, sclk, device_select_n};

    dcspi_sync #(
        .W   (SYNC_W),
        .RST (SYNC_RST)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .xing  (xing)
    );

    assign sy = xing.sync_out;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy_prev <= SYNC_RST;
        end else begin
            sy_prev <= sy;
        end
    end

    assign sel_rise  = sy[SYNC_SEL] & ~sy_prev[SYNC_SEL];
    assign sclk_fall = sy_prev[SYNC_SCLK] & ~sy[SYNC_SCLK];
    assign resync    = sy[SYNC_SCLK] & ~sy_prev[SYNC_SCLK] & sy[SYNC_SEL];
    assign rd_evt    = sy[SYNC_RD] ^ sy_prev[SYNC_RD];
    assign wr_evt    = sy[SYNC_WR] ^ sy_prev[SYNC_WR];
    assign ab_evt    = sy[SYNC_AB] ^ sy_prev[SYNC_AB];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state             <= DCSPI_IDLE;
            reg_rd_addr          <= BYTE_RST;
            rd_shift             <= BYTE_RST;
            serial_data_out      <= SDO_IDLE;
            serial_data_out_oe_n <= 1'b1;
        end else if (resync) begin
            rd_state             <= DCSPI_IDLE;
            serial_data_out      <= SDO_IDLE;
            serial_data_out_oe_n <= 1'b1;
        end else begin
            case (rd_state)
                DCSPI_IDLE: begin
                    if (rd_evt) begin
                        reg_rd_addr <= addr_hold;
                        rd_state    <= DCSPI_FETCH;
                    end
                end
                DCSPI_FETCH: begin
                    rd_shift <= reg_rd_hit ? reg_rd_data : BYTE_RST;
                    rd_state <= DCSPI_GAP;
                end
                DCSPI_GAP: begin
                    if (sy[SYNC_SEL]) begin
                        rd_state <= DCSPI_ARMED;
                    end
                end
                DCSPI_ARMED: begin
                    if (!sy[SYNC_SEL]) begin
                        serial_data_out      <= rd_shift[7];
                        serial_data_out_oe_n <= 1'b0;
                        rd_state             <= DCSPI_SHIFT;
                    end
                end
                DCSPI_SHIFT: begin
                    if (sel_rise) begin
                        serial_data_out      <= SDO_IDLE;
                        serial_data_out_oe_n <= 1'b1;
                        rd_state             <= DCSPI_IDLE;
                    end else if (sclk_fall) begin
                        rd_shift        <= {rd_shift[6:0], 1'b0};
                        serial_data_out <= rd_shift[6];
                    end
                end
                default: begin
                    rd_state <= DCSPI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state    <= DCSPI_WIDLE;
            reg_wr_en   <= 1'b0;
            reg_wr_addr <= BYTE_RST;
            reg_wr_data <= BYTE_RST;
        end else begin
            reg_wr_en <= 1'b0;
            case (wr_state)
                DCSPI_WIDLE: begin
                    if (wr_evt) begin
                        wr_state <= DCSPI_WPEND;
                    end
                end
                DCSPI_WPEND: begin
                    if (ab_evt) begin
                        wr_state <= DCSPI_WIDLE;
                    end else if (sel_rise) begin
                        reg_wr_addr <= addr_hold;
                        reg_wr_data <= wdata_hold;
                        wr_state    <= DCSPI_WADDR;
                    end
                end
                DCSPI_WADDR: begin
                    reg_wr_en <= reg_wr_hit;
                    wr_state  <= DCSPI_WIDLE;
                end
                default: begin
                    wr_state <= DCSPI_WIDLE;
                end
            endcase
        end
    end

    a_oe_read_only: assert property (
        @(posedge clk) disable iff (!rst_n)
        !serial_data_out_oe_n |-> rd_state == DCSPI_SHIFT)
        else $error("data out driven outside read byte");

    a_oe_off_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_state != DCSPI_WIDLE |-> serial_data_out_oe_n)
        else $error("data out driven during write");

    a_absent_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_state == DCSPI_FETCH && !resync && !reg_rd_hit) |=> rd_shift == 8'h00)
        else $error("absent register not read as zero");

    a_write_hit: assert property (
        @(posedge clk) disable iff (!rst_n)
        reg_wr_en |-> $past(wr_state) == DCSPI_WADDR && $past(reg_wr_hit))
        else $error("write strobe without valid address");

    a_abort_drop: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_state == DCSPI_WPEND && ab_evt) |=> wr_state == DCSPI_WIDLE && !reg_wr_en [*3])
        else $error("aborted write was committed");

    a_commit_rise: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_state == DCSPI_WPEND && sel_rise && !ab_evt)
        |=> wr_state == DCSPI_WADDR ##1 reg_wr_en == $past(reg_wr_hit))
        else $error("write not committed after select rise");

    a_out_on_fall: assert property (
        @(posedge clk) disable iff (!rst_n)
        ($changed(serial_data_out) && $past(rd_state) == DCSPI_SHIFT && !$past(sel_rise))
        |-> $past(sclk_fall))
        else $error("data out changed without falling clock");

    a_reset_idle: assert property (
        @(posedge clk) !rst_n |-> serial_data_out_oe_n && rd_state == DCSPI_IDLE)
        else $error("not idle during reset");

    a_resync_idx: assert property (
        @(posedge sclk) disable iff (!rst_n)
        device_select_n |=> byte_idx == IDX_CTRL && !lost)
        else $error("idle clock did not reset packet state");

    a_over_lost: assert property (
        @(posedge sclk) disable iff (!rst_n)
        (!device_select_n && bit_cnt == OVER_BIT_CNT) |=> lost)
        else $error("overclock did not drop sync");

    a_byte_eight: assert property (
        @(posedge sclk) disable iff (!rst_n)
        $rose(byte_full) |-> $past(bit_cnt) == LAST_BIT_CNT)
        else $error("byte completed off the eighth edge");

    a_read_target: assert property (
        @(posedge sclk) disable iff (!rst_n)
        $changed(rd_tgl) |-> $past(ctrl_rnw) && $past(ctrl_cid0))
        else $error("read answered by non-addressed device");

    a_write_target: assert property (
        @(posedge sclk) disable iff (!rst_n)
        $changed(wr_tgl) |-> !$past(ctrl_rnw) && ($past(ctrl_brd) || $past(ctrl_cid0)))
        else $error("write accepted by non-target device");

    a_borrow_stop: assert property (
        @(posedge sclk) disable iff (!rst_n)
        (cid_field && !device_select_n && serial_data_in && bit_cnt != LAST_BIT_CNT)
        |=> !borrow)
        else $error("decrement borrow not cleared by a one");

    c_read_byte: cover property (@(posedge clk) disable iff (!rst_n)
        rd_state == DCSPI_ARMED ##1 rd_state == DCSPI_SHIFT);
    c_write_commit: cover property (@(posedge clk) disable iff (!rst_n) reg_wr_en);
    c_write_abort: cover property (@(posedge clk) disable iff (!rst_n)
        wr_state == DCSPI_WPEND && ab_evt);
    c_resync: cover property (@(posedge sclk) disable iff (!rst_n)
        device_select_n && byte_idx != IDX_CTRL);
endmodule // dcspi_slave

// ---- rtl/dcspi_pkg.sv ----
package dcspi_pkg;
    // Serial framing
    localparam logic [3:0] CNT_RST       = 4'h0;
    localparam logic [3:0] CID_FIRST_CNT = 4'h3;
    localparam logic [3:0] LAST_BIT_CNT  = 4'h7;
    localparam logic [3:0] OVER_BIT_CNT  = 4'h8;
    localparam logic [1:0] IDX_CTRL      = 2'h0;
    localparam logic [1:0] IDX_ADDR      = 2'h1;
    localparam logic [1:0] IDX_DATA      = 2'h2;
    // Control byte fields
    localparam int unsigned BRD_POS = 7;
    localparam int unsigned RNW_POS = 6;
    localparam int unsigned CID_MSB = 4;
    localparam logic [4:0]  CID_ZERO = 5'h00;
    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic       SDO_IDLE = 1'b0;
    // Crossing into clk domain
    localparam int unsigned SYNC_W    = 5;
    localparam int unsigned SYNC_SEL  = 0;
    localparam int unsigned SYNC_SCLK = 1;
    localparam int unsigned SYNC_RD   = 2;
    localparam int unsigned SYNC_WR   = 3;
    localparam int unsigned SYNC_AB   = 4;
    localparam logic [SYNC_W-1:0] SYNC_RST = 5'h01;

    typedef enum logic [2:0] {
        DCSPI_IDLE,
        DCSPI_FETCH,
        DCSPI_GAP,
        DCSPI_ARMED,
        DCSPI_SHIFT
    } dcspi_rd_t;

    typedef enum logic [1:0] {
        DCSPI_WIDLE,
        DCSPI_WPEND,
        DCSPI_WADDR
    } dcspi_wr_t;
endpackage

// ---- rtl/dcspi_xing_if.sv ----
`timescale 1ns/1ps
interface dcspi_xing_if;
    import dcspi_pkg::*;
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync_out;
    modport src (output async_in, input sync_out);
    modport dst (input async_in, output sync_out);
endinterface

// ---- rtl/dcspi_sync.sv ----
`timescale 1ns/1ps
module dcspi_sync
    import dcspi_pkg::*;
#(
    parameter int unsigned     W   = SYNC_W,
    parameter logic [W-1:0]    RST = SYNC_RST
)(
    input  wire logic          clk,
    input  wire logic          rst_n,
    dcspi_xing_if.dst          xing
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;

    // Three-stage chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
        end else begin
            s1 <= xing.async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Bit follows only when second and third stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST;
        end else begin
            q <= (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
        end
    end

    assign xing.sync_out = q;
endmodule // dcspi_sync

// ---- tb/dcspi_master.sv ----
`timescale 1ns/1ps
module dcspi_master (
    output logic      sclk,
    output logic      device_select_n,
    output logic      serial_data_in,
    input  wire logic serial_data_out,
    input  wire logic serial_data_out_oe_n,
    input  wire logic serial_passthrough_out
);
    localparam realtime HALF = 32.0;
    logic miso_w;

    // Released line shows the inverse of data out, held at SDO_IDLE while released
    assign miso_w = serial_data_out_oe_n ? !serial_data_out : serial_data_out;

    initial begin
        sclk = 1'b0;
        device_select_n = 1'b1;
        serial_data_in = 1'b0;
    end

    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx,
                        output logic [7:0] thru, output logic drv);
        rx = 8'h00;
        thru = 8'h00;
        drv = 1'b0;
        device_select_n = 1'b0;
        #40.3;
        for (int i = 0; i < nbits; i++) begin
            serial_data_in = (i < 8) ? tx[7-i] : 1'b0;
            #HALF;
            sclk = 1'b1;
            if (i < 8) begin
                rx[7-i] = miso_w;
                thru[7-i] = serial_passthrough_out;
            end
            drv = drv | (serial_data_out_oe_n === 1'b0);
            #HALF;
            sclk = 1'b0;
        end
        #40.1;
        device_select_n = 1'b1;
        // Released line shows the inverse of its last bit
        serial_data_in = !serial_data_in;
        #60.7;
    endtask

    // resync by clock pulse with select high
    task automatic resync();
        device_select_n = 1'b1;
        #20.0;
        sclk = 1'b1;
        #HALF;
        sclk = 1'b0;
        #40.0;
    endtask

    task automatic packet(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                          input int dbits, output logic [7:0] rx, output logic [7:0] thru,
                          output logic [1:0] drv);
        logic [7:0] r0;
        logic [7:0] t0;
        logic       d0;
        logic       d1;
        logic       d2;
        xfer(c, 8, r0, thru, d0);
        xfer(a, 8, r0, t0, d1);
        xfer(d, dbits, rx, t0, d2);
        drv = {d2, d0 | d1};
    endtask
endmodule // dcspi_master

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import dcspi_pkg::*;
    localparam int LIMIT = 40000;
    logic       clk, rst_n, sclk, device_select_n, serial_data_in;
    logic       serial_data_out, serial_data_out_oe_n, serial_passthrough_out;
    logic [7:0] reg_rd_addr, reg_rd_data, reg_wr_addr, reg_wr_data;
    logic       reg_rd_hit, reg_wr_en, reg_wr_hit;
    logic [7:0] mem [0:7];
    logic [7:0] rx, thru;
    logic [1:0] drv;
    int         fail_count, n_tests, wr_count, cycles;

    dcspi_slave dcspi_slave_inst (.clk(clk), .rst_n(rst_n), .sclk(sclk),
        .device_select_n(device_select_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n),
        .serial_passthrough_out(serial_passthrough_out), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(reg_rd_data), .reg_rd_hit(reg_rd_hit), .reg_wr_en(reg_wr_en),
        .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_wr_hit(reg_wr_hit));
    dcspi_master dcspi_master_inst (.sclk(sclk), .device_select_n(device_select_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe_n(serial_data_out_oe_n),
        .serial_passthrough_out(serial_passthrough_out));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Small register bank: eight places, absent ones answer a non-zero pattern
    always @(negedge clk) begin
        reg_rd_hit <= (reg_rd_addr < 8'h08);
        reg_rd_data <= (reg_rd_addr < 8'h08) ? mem[reg_rd_addr[2:0]] : 8'h5a;
        reg_wr_hit <= (reg_wr_addr < 8'h08);
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (reg_wr_en === 1'b1) begin
            wr_count <= wr_count + 1;
            if (reg_wr_hit === 1'b1) begin
                mem[reg_wr_addr[2:0]] <= reg_wr_data;
            end
        end
        if (cycles == LIMIT) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] ctrl_of(input logic rd, input logic brd, input logic [4:0] id);
        return {brd, rd, 1'b0, id[0], id[1], id[2], id[3], id[4]};
    endfunction

    function automatic logic [7:0] thru_of(input logic [7:0] c);
        logic [4:0] nx;
        nx = {c[0], c[1], c[2], c[3], c[4]} - 5'h01;
        return {c[7:5], nx[0], nx[1], nx[2], nx[3], nx[4]};
    endfunction

    task automatic wr(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                      input int dbits);
        dcspi_master_inst.packet(c, a, d, dbits, rx, thru, drv);
        repeat (12) @(posedge clk);
        check({6'h00, drv}, 8'h00);
    endtask

    task automatic t_reset();
        check({6'h00, serial_data_out_oe_n, serial_data_out}, 8'h02);
        check({7'h00, reg_wr_en}, 8'h00);
    endtask

    task automatic t_write_read();
        wr(ctrl_of(1'b0, 1'b0, 5'h00), 8'h03, 8'ha5, 8);
        check(mem[3], 8'ha5);
        check(thru, thru_of(8'h00));
        dcspi_master_inst.packet(ctrl_of(1'b1, 1'b0, 5'h00), 8'h03, 8'h00, 8, rx, thru, drv);
        check(rx, 8'ha5);
        check({6'h00, drv}, 8'h02);
        check({7'h00, serial_data_out_oe_n}, 8'h01);
        check(thru, thru_of(8'h40));
    endtask

    task automatic t_absent();
        dcspi_master_inst.packet(ctrl_of(1'b1, 1'b0, 5'h00), 8'h20, 8'h00, 8, rx, thru, drv);
        check(rx, 8'h00);
        check(wr_count[7:0], 8'h01);
        wr(ctrl_of(1'b0, 1'b0, 5'h00), 8'h20, 8'h77, 8);
        check(wr_count[7:0], 8'h01);
    endtask

    task automatic t_chain();
        dcspi_master_inst.packet(ctrl_of(1'b1, 1'b1, 5'h00), 8'h03, 8'h00, 8, rx, thru, drv);
        check(rx, 8'ha5);
        dcspi_master_inst.packet(ctrl_of(1'b1, 1'b0, 5'h01), 8'h03, 8'h00, 8, rx, thru, drv);
        check({6'h00, drv}, 8'h00);
        check(thru, thru_of(ctrl_of(1'b1, 1'b0, 5'h01)));
        wr(ctrl_of(1'b0, 1'b0, 5'h0c), 8'h04, 8'h3c, 8);
        check(mem[4], 8'h00);
        check(thru, thru_of(ctrl_of(1'b0, 1'b0, 5'h0c)));
        wr(ctrl_of(1'b0, 1'b1, 5'h0c), 8'h04, 8'h3c, 8);
        check(mem[4], 8'h3c);
    endtask

    task automatic t_abort();
        wr(ctrl_of(1'b0, 1'b0, 5'h00), 8'h05, 8'h11, 5);
        check(mem[5], 8'h00);
        dcspi_master_inst.resync();
        wr(ctrl_of(1'b0, 1'b0, 5'h00), 8'h05, 8'h22, 9);
        check(mem[5], 8'h00);
        dcspi_master_inst.resync();
        wr(ctrl_of(1'b0, 1'b0, 5'h00), 8'h05, 8'h33, 8);
        check(mem[5], 8'h33);
        dcspi_master_inst.xfer(8'hff, 3, rx, thru, drv[0]);
        wr(ctrl_of(1'b0, 1'b0, 5'h00), 8'h06, 8'h44, 8);
        check(mem[6], 8'h44);
    endtask

    task automatic t_resync_mid();
        dcspi_master_inst.xfer(ctrl_of(1'b0, 1'b0, 5'h00), 8, rx, thru, drv[0]);
        dcspi_master_inst.xfer(8'h05, 8, rx, thru, drv[0]);
        dcspi_master_inst.resync();
        dcspi_master_inst.packet(ctrl_of(1'b1, 1'b0, 5'h00), 8'h05, 8'h00, 8, rx, thru, drv);
        check(rx, 8'h33);
        check(mem[5], 8'h33);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            mem[i] = 8'h00;
        end
        // Real falling edge so both clock domains see the reset
        rst_n = 1'b1;
        #1;
        rst_n = 1'b0;
        // Link clock ticks once in reset so its checks start from known history
        fork
            dcspi_master_inst.resync();
        join_none
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        t_reset();
        t_write_read();
        t_absent();
        t_chain();
        t_abort();
        t_resync_mid();
        complete_run();
    end
endmodule // testbench
